// ---- ugr_global_regs.sv ----
// usb global registers: function enable, device address, event flags, enables, endpoint index
// assumes: line state from the transceiver is asynchronous; sof_ok and remote_resume
// come from the serial engine on clk; address_valid comes from the global control register
//
// What this block does
// - function_on cleared at power-up or by a firmware write, not by bus reset
// - address field zero after power-up, bus reset
// - bus resume during suspend sets wake_flag
// - end of bus reset sets sticky flag
// - error-free sof sets sticky flag
// - idle j 3 ms sets suspend flag
// - flag raises interrupt only when enabled
// - enable register resets to 0x10
// - reserved bits read zero, ignore writes
// - endpoint index steers per-endpoint registers
// - address register reads zero after power-up
// - se0 for 32 bit times means reset
// - answer address zero until address valid
module ugr_global_regs #(
    parameter int SUSPEND_CYCLES = ugr_pkg::UGR_SUSPEND_CYCLES,
    parameter int RESET_CYCLES   = ugr_pkg::UGR_RESET_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       clk_en,
    // sfr port
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    output logic      [7:0] sfr_rdata,
    // bus side
    input  wire logic [1:0] line_state,
    input  wire logic       sof_ok,
    input  wire logic       remote_resume,
    input  wire logic       address_valid,
    // outputs to the rest of the controller
    output logic            function_on,
    output logic      [6:0] match_addr,
    output logic      [1:0] endpoint_index,
    output logic            usb_irq,
    output logic            bus_reset
);

    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic [7:0] enables_reg;
    logic [6:0] dev_addr_field;
    logic [1:0] line_s1_reg;
    logic [1:0] line_s2_reg;
    logic       se0_reg;
    logic       suspended_reg;
    logic       rst_hit;
    logic       susp_hit;
    logic       wake_ev;
    logic       reset_end_ev;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic hit_addr(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    // ----------------------------------------------------------------
    // line synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            line_s1_reg <= ugr_pkg::UGR_LINE_J;
            line_s2_reg <= ugr_pkg::UGR_LINE_J;
        end
        else if (clk_en)
        begin
            line_s1_reg <= line_state;
            line_s2_reg <= line_s1_reg;
        end
    end

    wire se0_now  = line_s2_reg == ugr_pkg::UGR_LINE_SE0;
    wire idle_now = line_s2_reg == ugr_pkg::UGR_LINE_J;

    // ----------------------------------------------------------------
    // bus reset and suspend detection
    // ----------------------------------------------------------------
    ugr_idle_timer #(
        .LIMIT (RESET_CYCLES),
        .CW    (16)
    ) u_reset_timer (
        .clk     (clk),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .cond    (se0_now),
        .hit     (rst_hit)
    );

    ugr_idle_timer #(
        .LIMIT (SUSPEND_CYCLES),
        .CW    (24)
    ) u_suspend_timer (
        .clk     (clk),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .cond    (idle_now),
        .hit     (susp_hit)
    );

    // in-reset state: set on reset detect, end of reset when se0 goes away
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            se0_reg   <= 1'b0;
            bus_reset <= 1'b0;
        end
        else if (clk_en)
        begin
            bus_reset <= rst_hit;
            if (rst_hit)
                se0_reg <= 1'b1;
            else if (!se0_now)
                se0_reg <= 1'b0;
        end
    end

    assign reset_end_ev = se0_reg && !se0_now;

    // suspended state; own resume signalling must not count as a wake
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            suspended_reg <= 1'b0;
        else if (clk_en)
        begin
            if (susp_hit)
                suspended_reg <= 1'b1;
            else if (!idle_now || remote_resume)
                suspended_reg <= 1'b0;
        end
    end

    assign wake_ev = suspended_reg && !idle_now && !remote_resume;

    // ----------------------------------------------------------------
    // event flags
    // ----------------------------------------------------------------
    always_comb
    begin
        flags_next = flags_reg;
        // software writes zero to clear; a one leaves the bit alone
        if (clk_en && sfr_wr && hit_addr(sfr_addr, ugr_pkg::UGR_FLAGS_ADDR))
            flags_next = flags_reg & sfr_wdata;
        // hardware set after the clear so a same-cycle event is kept
        if (wake_ev)
            flags_next[ugr_pkg::UGR_WAKE_BIT] = 1'b1;
        if (reset_end_ev)
            flags_next[ugr_pkg::UGR_RESET_END_BIT] = 1'b1;
        if (sof_ok)
            flags_next[ugr_pkg::UGR_FRAME_BIT] = 1'b1;
        if (susp_hit)
            flags_next[ugr_pkg::UGR_SUSPEND_BIT] = 1'b1;
        flags_next = flags_next & ugr_pkg::UGR_EVENT_MASK;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            flags_reg <= ugr_pkg::UGR_FLAGS_RST;
        else if (clk_en)
            flags_reg <= flags_next;
    end

    // ----------------------------------------------------------------
    // enables
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            enables_reg <= ugr_pkg::UGR_ENABLES_RST;
        else if (clk_en && sfr_wr && hit_addr(sfr_addr, ugr_pkg::UGR_ENABLES_ADDR))
            enables_reg <= sfr_wdata & ugr_pkg::UGR_EVENT_MASK;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            usb_irq <= 1'b0;
        else if (clk_en)
            usb_irq <= |(flags_next & enables_reg);
    end

    // ----------------------------------------------------------------
    // device address and function enable
    // ----------------------------------------------------------------
    // function_on is cleared by power-up reset or a firmware write of bit 7, never by bus reset
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            function_on <= 1'b0;
        else if (clk_en && sfr_wr && hit_addr(sfr_addr, ugr_pkg::UGR_DEVADDR_ADDR))
            function_on <= sfr_wdata[ugr_pkg::UGR_FUNC_ON_BIT];
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            dev_addr_field <= ugr_pkg::UGR_DEVADDR_RST[6:0];
        else if (clk_en)
        begin
            if (rst_hit)
                dev_addr_field <= '0;
            else if (sfr_wr && hit_addr(sfr_addr, ugr_pkg::UGR_DEVADDR_ADDR))
                dev_addr_field <= sfr_wdata[6:0];
        end
    end

    // registered match address; default zero until firmware marks it valid
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            match_addr <= '0;
        else if (clk_en)
            match_addr <= address_valid ? dev_addr_field : 7'h00;
    end

    // ----------------------------------------------------------------
    // endpoint index
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            endpoint_index <= ugr_pkg::UGR_EPIDX_RST;
        else if (clk_en && sfr_wr && hit_addr(sfr_addr, ugr_pkg::UGR_EPIDX_ADDR))
            endpoint_index <= sfr_wdata[1:0];
    end

    // ----------------------------------------------------------------
    // read data; registered, so it lags the read strobe by one cycle
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            sfr_rdata <= 8'h00;
        else if (clk_en && sfr_rd)
        begin
            case (sfr_addr)
                ugr_pkg::UGR_FLAGS_ADDR:   sfr_rdata <= flags_reg;
                ugr_pkg::UGR_ENABLES_ADDR: sfr_rdata <= enables_reg;
                ugr_pkg::UGR_DEVADDR_ADDR: sfr_rdata <= {function_on, dev_addr_field};
                ugr_pkg::UGR_EPIDX_ADDR:   sfr_rdata <= {6'h00, endpoint_index};
                default:                   sfr_rdata <= 8'h00;
            endcase
        end
    end

endmodule // ugr_global_regs

// ---- ugr_pkg.sv ----
// package: register map, field positions, reset values and timing for the usb global regs
// assumes: an 8-bit special-function-register port on the microcontroller side
package ugr_pkg;

    // ----------------------------------------------------------------
    // register offsets (sfr addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] UGR_FLAGS_ADDR   = 8'hbd;
    localparam logic [7:0] UGR_ENABLES_ADDR = 8'hbe;
    localparam logic [7:0] UGR_DEVADDR_ADDR = 8'hc6;
    localparam logic [7:0] UGR_EPIDX_ADDR   = 8'hc7;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int UGR_WAKE_BIT      = 5;
    localparam int UGR_RESET_END_BIT = 4;
    localparam int UGR_FRAME_BIT     = 3;
    localparam int UGR_SUSPEND_BIT   = 0;
    localparam int UGR_FUNC_ON_BIT   = 7;
    localparam int UGR_ADDR_W        = 7;
    localparam int UGR_EPIDX_W       = 2;

    // implemented bits of the flag and enable registers; the rest read zero
    localparam logic [7:0] UGR_EVENT_MASK   = 8'h39;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] UGR_ENABLES_RST  = 8'h10;
    localparam logic [7:0] UGR_DEVADDR_RST  = 8'h00;
    localparam logic [7:0] UGR_FLAGS_RST    = 8'h00;
    localparam logic [1:0] UGR_EPIDX_RST    = 2'h0;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int UGR_CLK_MHZ        = 125;
    // bus reset: se0 for 32 full-speed bit times (12 mbit/s)
    localparam int UGR_RESET_BITS     = 32;
    localparam int UGR_FS_MBPS        = 12;
    localparam int UGR_RESET_CYCLES   = (UGR_RESET_BITS * UGR_CLK_MHZ + UGR_FS_MBPS - 1)
                                        / UGR_FS_MBPS;
    // suspend: idle j state for 3 ms
    localparam int UGR_SUSPEND_MS     = 3;
    localparam int UGR_SUSPEND_CYCLES = UGR_SUSPEND_MS * 1000 * UGR_CLK_MHZ;

    // line states sampled from the transceiver
    localparam logic [1:0] UGR_LINE_SE0 = 2'h0;
    localparam logic [1:0] UGR_LINE_J   = 2'h1;

endpackage // ugr_pkg

// ---- ugr_idle_timer.sv ----
// idle timer: counts cycles while a condition holds, pulses once on reaching the limit
// assumes: cond is already synchronised to clk
module ugr_idle_timer #(
    parameter int LIMIT = 16,
    parameter int CW    = 24
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic clk_en,
    input  wire logic cond,
    output logic      hit
);

    logic [CW-1:0] cnt_reg;
    logic          done_reg;

    // ----------------------------------------------------------------
    // counter; saturates so one long condition gives one pulse
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            cnt_reg  <= '0;
            done_reg <= 1'b0;
            hit      <= 1'b0;
        end
        else if (clk_en)
        begin
            hit <= 1'b0;
            if (!cond)
            begin
                cnt_reg  <= '0;
                done_reg <= 1'b0;
            end
            else if (!done_reg)
            begin
                if (cnt_reg == CW'(LIMIT - 1))
                begin
                    done_reg <= 1'b1;
                    hit      <= 1'b1;
                end
                else
                begin
                    cnt_reg <= cnt_reg + CW'(1);
                end
            end
        end
    end

endmodule // ugr_idle_timer

// ---- ugr_host_model.sv ----
// host model: drives the line state and the sof strobe seen by the usb global regs
// assumes: called from the bench; each call starts just after a rising clk edge
module ugr_host_model (
    input  wire logic       clk,
    output logic      [1:0] line_state,
    output logic            sof_ok
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus rests in j, held there by the device pull-up
    initial
    begin
        line_state = ugr_pkg::UGR_LINE_J;
        sof_ok     = 1'b0;
    end

    // hold one line state for n cycles
    task automatic drive(input logic [1:0] st, input int n);
        @(posedge clk);
        line_state <= st;
        repeat (n - 1) @(posedge clk);
    endtask

    // a packet is non-idle on the line, so it also restarts the idle timer
    task automatic sof();
        drive(2'h2, 2);
        @(posedge clk);
        line_state <= ugr_pkg::UGR_LINE_J;
        sof_ok     <= 1'b1;
        @(posedge clk);
        sof_ok <= 1'b0;
    endtask
endmodule // ugr_host_model

// ---- ugr_global_regs_properties.sv ----
// checker: port timing of the usb global regs
// assumes: bound into ugr_global_regs; clk_en stays high while se0 lasts
module ugr_global_regs_properties #(
    parameter int SUSPEND_CYCLES = 200,
    parameter int RESET_CYCLES   = 8
) (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       clk_en,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic [1:0] line_state,
    input wire logic       sof_ok,
    input wire logic       remote_resume,
    input wire logic       address_valid,
    input wire logic       function_on,
    input wire logic [6:0] match_addr,
    input wire logic [1:0] endpoint_index,
    input wire logic       usb_irq,
    input wire logic       bus_reset
);
    localparam logic [7:0] MASK = ugr_pkg::UGR_EVENT_MASK;
    // ----------------------------------------------------------------
    // shadow state
    // ----------------------------------------------------------------
    logic [7:0] en_reg;
    logic [6:0] addr_reg;
    int         se0_reg;
    logic       got_reg;
    wire        wr_on = clk_en && sfr_wr;
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            en_reg <= ugr_pkg::UGR_ENABLES_RST;
        else if (wr_on && sfr_addr == ugr_pkg::UGR_ENABLES_ADDR)
            en_reg <= sfr_wdata & MASK;
    end
    // the design clears on the edge that raises bus_reset, a cycle before this shadow does, so a write there must win here
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            addr_reg <= 7'h00;
        else if (wr_on && sfr_addr == ugr_pkg::UGR_DEVADDR_ADDR)
            addr_reg <= sfr_wdata[6:0];
        else if (bus_reset)
            addr_reg <= 7'h00;
    end
    // raw se0 run length; counts the sync stages too, so bounds carry slack
    always_ff @(posedge clk)
    begin
        se0_reg <= (line_state == ugr_pkg::UGR_LINE_SE0) ? se0_reg + 1 : 0;
        got_reg <= (line_state == ugr_pkg::UGR_LINE_SE0) && (got_reg || bus_reset);
    end
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_sof_en;
        clk_en && sof_ok && en_reg[ugr_pkg::UGR_FRAME_BIT];
    endsequence
    sequence s_evt_rd;
        clk_en && sfr_rd && sfr_addr[7:4] == 4'hb;
    endsequence
    reserved_read_zero_a: assert property (s_evt_rd |=> (sfr_rdata & ~MASK) == 8'h00)
        else $error("reserved bits read nonzero");
    sof_irq_a: assert property (s_sof_en |=> usb_irq)
        else $error("enabled sof gave no interrupt");
    irq_masked_a: assert property (((en_reg & MASK) == 8'h00 && clk_en) [*2] |-> !usb_irq)
        else $error("interrupt with all enables clear");
    addr_default_a: assert property (clk_en && !address_valid |=> match_addr == 7'h00)
        else $error("address not default");
    addr_follow_a: assert property (clk_en && address_valid && !bus_reset
        |=> match_addr == $past(addr_reg)) else $error("address not programmed value");
    reset_pulse_a: assert property (bus_reset && clk_en |=> !bus_reset)
        else $error("bus reset pulse too long");
    reset_late_a: assert property (bus_reset |-> se0_reg >= RESET_CYCLES)
        else $error("bus reset on short se0");
    reset_timely_a: assert property (se0_reg == RESET_CYCLES + 6 |-> got_reg)
        else $error("bus reset missed");
    ep_index_a: assert property (wr_on && sfr_addr == ugr_pkg::UGR_EPIDX_ADDR
        |=> endpoint_index == $past(sfr_wdata[1:0])) else $error("endpoint index wrong");
    func_write_a: assert property (wr_on && sfr_addr == ugr_pkg::UGR_DEVADDR_ADDR
        |=> function_on == $past(sfr_wdata[7])) else $error("function enable wrong");
endmodule // ugr_global_regs_properties

bind ugr_global_regs ugr_global_regs_properties #(
    .SUSPEND_CYCLES(SUSPEND_CYCLES),
    .RESET_CYCLES  (RESET_CYCLES)
) i_props (
    .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .line_state(line_state), .sof_ok(sof_ok), .remote_resume(remote_resume),
    .address_valid(address_valid), .function_on(function_on), .match_addr(match_addr),
    .endpoint_index(endpoint_index), .usb_irq(usb_irq), .bus_reset(bus_reset)
);

// ---- tb_top.sv ----
// testbench: register access, line events and address match of the usb global regs
// assumes: host model owns the line; short counts keep the run brief
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int         SUSP  = 200;
    localparam int         RST   = 8;
    localparam logic [1:0] SE0   = 2'h0;
    localparam logic [1:0] J     = 2'h1;
    localparam logic [1:0] K     = 2'h2;
    localparam logic [7:0] A_FLG = ugr_pkg::UGR_FLAGS_ADDR;
    localparam logic [7:0] A_EN  = ugr_pkg::UGR_ENABLES_ADDR;
    localparam logic [7:0] A_DEV = ugr_pkg::UGR_DEVADDR_ADDR;
    localparam logic [7:0] A_EP  = ugr_pkg::UGR_EPIDX_ADDR;
    logic       clk = 1'b0;
    logic       reset_n, clk_en, sfr_wr, sfr_rd, remote_resume, address_valid;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [1:0] line_state, endpoint_index;
    logic       sof_ok, function_on, usb_irq, bus_reset;
    logic [6:0] match_addr;
    int         errors = 0;
    int         total_checks = 0;
    logic [7:0] map_a [5] = '{A_FLG, A_EN, A_DEV, A_EP, 8'hc0};
    logic [7:0] map_r [5] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00};

    always #4 clk = ~clk;

    ugr_global_regs #(.SUSPEND_CYCLES(SUSP), .RESET_CYCLES(RST)) i_dut (
        .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .line_state(line_state), .sof_ok(sof_ok), .remote_resume(remote_resume),
        .address_valid(address_valid), .function_on(function_on), .match_addr(match_addr),
        .endpoint_index(endpoint_index), .usb_irq(usb_irq), .bus_reset(bus_reset)
    );
    ugr_host_model i_host (.clk(clk), .line_state(line_state), .sof_ok(sof_ok));

    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1 check(sfr_rdata, exp);
    endtask
    // irq is registered off the next flag value; three edges leave slack
    task automatic irq_is(input logic v);
        repeat (3) @(posedge clk);
        #1 check({7'h00, usb_irq}, {7'h00, v});
    endtask
    task automatic print_verdict;
        $display("checks %0d, errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        {reset_n, sfr_wr, sfr_rd, remote_resume, address_valid} = '0;
        {sfr_addr, sfr_wdata} = '0;
        clk_en = 1'b1;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        foreach (map_a[i]) rd(map_a[i], map_r[i]);
        wr(A_EN, 8'hff);
        rd(A_EN, 8'h39);
        wr(A_EP, 8'hff);
        rd(A_EP, 8'h03);
        wr(8'hc0, 8'hff);
        rd(8'hc0, 8'h00);
        @(posedge clk) clk_en <= 1'b0;
        wr(A_EP, 8'h01);
        @(posedge clk) clk_en <= 1'b1;
        #1 check({6'h00, endpoint_index}, 8'h03);
        wr(A_DEV, 8'ha5);
        rd(A_DEV, 8'ha5);
        check({1'b0, match_addr}, 8'h00);
        @(posedge clk) address_valid <= 1'b1;
        irq_is(1'b0);
        check({1'b0, match_addr}, 8'h25);
        @(posedge clk) address_valid <= 1'b0;
        wr(A_EN, 8'h08);
        i_host.sof();
        irq_is(1'b1);
        rd(A_FLG, 8'h08);
        wr(A_FLG, 8'hff);
        rd(A_FLG, 8'h08);
        wr(A_FLG, 8'hf7);
        rd(A_FLG, 8'h00);
        wr(A_EN, 8'h00);
        i_host.sof();
        irq_is(1'b0);
        // sof strobe and a clearing write land on the same edge
        fork
            i_host.sof();
            begin
                repeat (2) @(posedge clk);
                wr(A_FLG, 8'h00);
            end
        join
        rd(A_FLG, 8'h08);
        wr(A_FLG, 8'h00);
        wr(A_EN, 8'h10);
        i_host.drive(SE0, RST - 3);
        i_host.drive(J, 4);
        rd(A_DEV, 8'ha5);
        i_host.drive(SE0, RST + 10);
        i_host.drive(J, 4);
        rd(A_DEV, 8'h80);
        rd(A_FLG, 8'h10);
        irq_is(1'b1);
        wr(A_FLG, 8'h00);
        wr(A_EN, 8'h21);
        i_host.drive(J, SUSP - 40);
        rd(A_FLG, 8'h00);
        i_host.drive(J, 60);
        rd(A_FLG, 8'h01);
        irq_is(1'b1);
        wr(A_FLG, 8'h00);
        i_host.drive(K, 4);
        i_host.drive(J, 4);
        rd(A_FLG, 8'h20);
        wr(A_FLG, 8'h00);
        i_host.drive(J, SUSP + 20);
        wr(A_FLG, 8'h00);
        @(posedge clk) remote_resume <= 1'b1;
        i_host.drive(K, 4);
        i_host.drive(J, 4);
        @(posedge clk) remote_resume <= 1'b0;
        rd(A_FLG, 8'h00);
        print_verdict();
    end

    // whole run is near 600 cycles
    initial
    begin
        repeat (6000) @(posedge clk);
        errors++;
        print_verdict();
    end
endmodule // tb_top
